// >>> inc/timer8_map.vh
// Constants for the 8-bit timer waveform block: mode codes, action codes,
// AHB-Lite register offsets, field positions and reset values.
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH
`define MODE_NORMAL      3'h0
`define MODE_PHASE_FF    3'h1
`define MODE_CLEAR_MATCH 3'h2
`define MODE_FAST_FF     3'h3
`define MODE_PHASE_CMP   3'h5
`define MODE_FAST_CMP    3'h7
`define ACT_OFF          2'h0
`define ACT_TOGGLE       2'h1
`define ACT_CLEAR        2'h2
`define ACT_SET          2'h3
`define ADDR_CONTROL     8'h00
`define ADDR_COUNTER     8'h04
`define ADDR_CMP_A       8'h08
`define ADDR_CMP_B       8'h0C
`define ADDR_FLAGS       8'h10
`define CTL_MODE_LSB     0
`define CTL_ACT_B_LSB    4
`define CTL_ACT_A_LSB    6
`define FLG_OVF          0
`define FLG_CMP_A        1
`define FLG_CMP_B        2
`define CNT_MAX          8'hFF
`define CNT_BOTTOM       8'h00
`define RESET_BYTE       8'h00
`endif

// >>> logic/timer8_waveform_modes.v
// 8-bit timer/counter with normal, clear-on-match, fast and phase-correct
// PWM modes, two compare outputs and an AHB-Lite register slave.
// Assumes a single AHB-Lite master, a prescaler enable on hclk and that
// the output pins are plain drive-only outputs.
`timescale 1ns/100ps
`include "timer8_map.vh"
module timer8_waveform_modes
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        timer_tick,
  output wire        compare_output_a,
  output wire        compare_output_b,
  output wire        compare_output_a_en,
  output wire        compare_output_b_en
);

  reg  [2:0]  waveform_mode_select_reg;
  reg  [1:0]  compare_action_a_reg;
  reg  [1:0]  compare_action_b_reg;
  reg  [7:0]  counter_value_reg;
  reg  [7:0]  cmp_buf_a_reg;
  reg  [7:0]  cmp_buf_b_reg;
  reg  [7:0]  compare_value_a_reg;
  reg  [7:0]  compare_value_b_reg;
  reg         overflow_flag_reg;
  reg         compare_flag_a_reg;
  reg         compare_flag_b_reg;
  reg         out_a_reg;
  reg         out_b_reg;
  reg         count_down_reg;
  reg         block_match_reg;
  reg         up_seen_a_reg;
  reg         up_seen_b_reg;
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  reg  [31:0] hrdata_reg;

  wire [7:0]  byte_addr;
  wire        bus_take;
  wire        wr_ctl;
  wire        wr_cnt;
  wire        wr_cmp_a;
  wire        wr_cmp_b;
  wire        wr_flg;
  wire [7:0]  wbyte;
  wire        mode_fast;
  wire        mode_phase;
  wire        mode_pwm;
  wire        mode_ctc;
  wire        sym_a;
  wire        sym_b;
  wire [7:0]  top_val;
  wire        at_top;
  wire        at_bottom;
  wire        match_a;
  wire        match_b;

  reg  [7:0]  counter_value_next;
  reg         count_down_next;
  reg         ovf_event;
  reg         cmpa_event;
  reg         cmpb_event;
  reg         out_a_next;
  reg         out_b_next;
  reg         load_buffers;

  // AHB-Lite address phase capture; zero wait states, always OKAY
  assign bus_take  = hsel & hready & htrans[1];
  assign byte_addr = {haddr[7:2], 2'b00};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign wbyte     = hwdata[7:0];
  assign wr_ctl    = wr_pend_reg & (wr_addr_reg == `ADDR_CONTROL);
  assign wr_cnt    = wr_pend_reg & (wr_addr_reg == `ADDR_COUNTER);
  assign wr_cmp_a  = wr_pend_reg & (wr_addr_reg == `ADDR_CMP_A);
  assign wr_cmp_b  = wr_pend_reg & (wr_addr_reg == `ADDR_CMP_B);
  assign wr_flg    = wr_pend_reg & (wr_addr_reg == `ADDR_FLAGS);

  // Mode decode; reserved codes fall back to normal counting
  assign mode_fast  = (waveform_mode_select_reg == `MODE_FAST_FF) |
                      (waveform_mode_select_reg == `MODE_FAST_CMP);
  assign mode_phase = (waveform_mode_select_reg == `MODE_PHASE_FF) |
                      (waveform_mode_select_reg == `MODE_PHASE_CMP);
  assign mode_ctc   = (waveform_mode_select_reg == `MODE_CLEAR_MATCH);
  assign mode_pwm   = mode_fast | mode_phase;
  assign top_val    = waveform_mode_select_reg[2] ? compare_value_a_reg
                                                  : `CNT_MAX;
  assign at_top     = (counter_value_reg == top_val);
  assign at_bottom  = (counter_value_reg == `CNT_BOTTOM);
  assign match_a    = (counter_value_reg == compare_value_a_reg) &
                      ~block_match_reg;
  assign match_b    = (counter_value_reg == compare_value_b_reg) &
                      ~block_match_reg;

  // Bottom turn with no up-slope match since the last one; a compare
  // value equal to top never matches on the way up, so it is left alone
  assign sym_a = at_bottom & count_down_reg & ~up_seen_a_reg &
                 (compare_value_a_reg != top_val);
  assign sym_b = at_bottom & count_down_reg & ~up_seen_b_reg &
                 (compare_value_b_reg != top_val);

  // Output enables: any nonzero, non-reserved action connects the pin
  assign compare_output_a_en = (compare_action_a_reg[1]) |
                               ((compare_action_a_reg == `ACT_TOGGLE) &
                                (~mode_pwm | waveform_mode_select_reg[2]));
  assign compare_output_b_en = compare_action_b_reg[1] |
                               ((compare_action_b_reg == `ACT_TOGGLE) &
                                ~mode_pwm);
  assign compare_output_a = out_a_reg;
  assign compare_output_b = out_b_reg;

  // Counter sequencing by mode and compare A, action bits never enter here
  always @*
  begin
    counter_value_next = counter_value_reg;
    count_down_next    = count_down_reg;
    ovf_event          = 1'b0;
    load_buffers       = 1'b0;
    if (mode_fast)
    begin
      if (at_top)
      begin
        counter_value_next = `CNT_BOTTOM;
        ovf_event          = 1'b1;
        load_buffers       = 1'b1;
      end
      else
        counter_value_next = counter_value_reg + 8'h01;
    end
    else if (mode_phase)
    begin
      if (at_top & ~count_down_reg)
      begin
        count_down_next    = 1'b1;
        load_buffers       = 1'b1;
        counter_value_next = counter_value_reg - 8'h01;
      end
      else if (at_bottom & count_down_reg)
      begin
        count_down_next    = 1'b0;
        counter_value_next = counter_value_reg + 8'h01;
      end
      else if (count_down_reg)
        counter_value_next = counter_value_reg - 8'h01;
      else
        counter_value_next = counter_value_reg + 8'h01;
      if (counter_value_next == `CNT_BOTTOM)
        ovf_event = 1'b1;
    end
    else if (mode_ctc & match_a)
    begin
      counter_value_next = `CNT_BOTTOM;
      ovf_event          = (counter_value_reg == `CNT_MAX);
    end
    else
    begin
      counter_value_next = counter_value_reg + 8'h01;
      if (counter_value_reg == `CNT_MAX)
        ovf_event = 1'b1;
    end
    cmpa_event = match_a;
    cmpb_event = match_b;
  end

  // Waveform generation for both outputs
  always @*
  begin
    out_a_next = out_a_reg;
    out_b_next = out_b_reg;
    if (mode_fast)
    begin
      if (at_top & compare_action_a_reg[1])
        out_a_next = ~compare_action_a_reg[0];
      else if (match_a & compare_action_a_reg[1])
        out_a_next = compare_action_a_reg[0];
      else if (match_a & (compare_action_a_reg == `ACT_TOGGLE) &
               waveform_mode_select_reg[2])
        out_a_next = ~out_a_reg;
      if (at_top & compare_action_b_reg[1])
        out_b_next = ~compare_action_b_reg[0];
      else if (match_b & compare_action_b_reg[1])
        out_b_next = compare_action_b_reg[0];
    end
    else if (mode_phase)
    begin
      // A match takes the level of the slope that follows it: at top it
      // acts as a down match, at bottom as an up match
      if (compare_action_a_reg[1])
      begin
        if (match_a)
          out_a_next = compare_action_a_reg[0] ^ count_down_next;
        else if (sym_a)
          out_a_next = compare_action_a_reg[0];
      end
      else if (match_a & (compare_action_a_reg == `ACT_TOGGLE) &
               waveform_mode_select_reg[2])
        out_a_next = ~out_a_reg;
      if (compare_action_b_reg[1])
      begin
        if (match_b)
          out_b_next = compare_action_b_reg[0] ^ count_down_next;
        else if (sym_b)
          out_b_next = compare_action_b_reg[0];
      end
    end
    else
    begin
      case (compare_action_a_reg)
        `ACT_TOGGLE: if (match_a) out_a_next = ~out_a_reg;
        `ACT_CLEAR:  if (match_a) out_a_next = 1'b0;
        `ACT_SET:    if (match_a) out_a_next = 1'b1;
        default:     out_a_next = out_a_reg;
      endcase
      case (compare_action_b_reg)
        `ACT_TOGGLE: if (match_b) out_b_next = ~out_b_reg;
        `ACT_CLEAR:  if (match_b) out_b_next = 1'b0;
        `ACT_SET:    if (match_b) out_b_next = 1'b1;
        default:     out_b_next = out_b_reg;
      endcase
    end
  end

  // Bus data phase, register state and timer stepping
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg              <= 1'b0;
      wr_addr_reg              <= 8'h00;
      hrdata_reg               <= 32'h00000000;
      waveform_mode_select_reg <= 3'h0;
      compare_action_a_reg     <= 2'h0;
      compare_action_b_reg     <= 2'h0;
      counter_value_reg        <= `RESET_BYTE;
      cmp_buf_a_reg            <= `RESET_BYTE;
      cmp_buf_b_reg            <= `RESET_BYTE;
      compare_value_a_reg      <= `RESET_BYTE;
      compare_value_b_reg      <= `RESET_BYTE;
      overflow_flag_reg        <= 1'b0;
      compare_flag_a_reg       <= 1'b0;
      compare_flag_b_reg       <= 1'b0;
      out_a_reg                <= 1'b0;
      out_b_reg                <= 1'b0;
      count_down_reg           <= 1'b0;
      block_match_reg          <= 1'b0;
      up_seen_a_reg            <= 1'b0;
      up_seen_b_reg            <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= bus_take & hwrite;
      wr_addr_reg <= byte_addr;
      if (bus_take & ~hwrite)
      begin
        case (byte_addr)
          `ADDR_CONTROL: hrdata_reg <= {24'h000000, compare_action_a_reg,
                                        compare_action_b_reg, 1'b0,
                                        waveform_mode_select_reg};
          `ADDR_COUNTER: hrdata_reg <= {24'h000000, counter_value_reg};
          `ADDR_CMP_A:   hrdata_reg <= {24'h000000, cmp_buf_a_reg};
          `ADDR_CMP_B:   hrdata_reg <= {24'h000000, cmp_buf_b_reg};
          `ADDR_FLAGS:   hrdata_reg <= {29'h00000000, compare_flag_b_reg,
                                        compare_flag_a_reg, overflow_flag_reg};
          default:       hrdata_reg <= 32'h00000000;
        endcase
      end
      if (wr_ctl)
      begin
        waveform_mode_select_reg <= wbyte[`CTL_MODE_LSB+2:`CTL_MODE_LSB];
        compare_action_b_reg     <= wbyte[`CTL_ACT_B_LSB+1:`CTL_ACT_B_LSB];
        compare_action_a_reg     <= wbyte[`CTL_ACT_A_LSB+1:`CTL_ACT_A_LSB];
      end
      if (wr_cmp_a)
        cmp_buf_a_reg <= wbyte;
      if (wr_cmp_b)
        cmp_buf_b_reg <= wbyte;
      // Unbuffered outside PWM; PWM loads at top only
      if (~mode_pwm)
      begin
        compare_value_a_reg <= wr_cmp_a ? wbyte : cmp_buf_a_reg;
        compare_value_b_reg <= wr_cmp_b ? wbyte : cmp_buf_b_reg;
      end
      else if (timer_tick & load_buffers)
      begin
        compare_value_a_reg <= cmp_buf_a_reg;
        compare_value_b_reg <= cmp_buf_b_reg;
      end
      if (wr_cnt)
        block_match_reg <= 1'b1;
      else if (timer_tick)
        block_match_reg <= 1'b0;
      if (wr_cnt)
        counter_value_reg <= wbyte;
      else if (timer_tick)
      begin
        counter_value_reg <= counter_value_next;
        count_down_reg    <= mode_phase ? count_down_next : 1'b0;
      end
      // Up-slope match memory for the symmetry fix at bottom
      if (wr_cnt | ~mode_phase)
      begin
        up_seen_a_reg <= 1'b0;
        up_seen_b_reg <= 1'b0;
      end
      else if (timer_tick & at_bottom & count_down_reg)
      begin
        up_seen_a_reg <= 1'b0;
        up_seen_b_reg <= 1'b0;
      end
      else if (timer_tick)
      begin
        up_seen_a_reg <= up_seen_a_reg | (match_a & ~count_down_next);
        up_seen_b_reg <= up_seen_b_reg | (match_b & ~count_down_next);
      end
      if (timer_tick)
      begin
        out_a_reg <= out_a_next;
        out_b_reg <= out_b_next;
      end
      // Flags: set wins over write-one-to-clear
      if (timer_tick & ovf_event)
        overflow_flag_reg <= 1'b1;
      else if (wr_flg & wbyte[`FLG_OVF])
        overflow_flag_reg <= 1'b0;
      if (timer_tick & cmpa_event)
        compare_flag_a_reg <= 1'b1;
      else if (wr_flg & wbyte[`FLG_CMP_A])
        compare_flag_a_reg <= 1'b0;
      if (timer_tick & cmpb_event)
        compare_flag_b_reg <= 1'b1;
      else if (wr_flg & wbyte[`FLG_CMP_B])
        compare_flag_b_reg <= 1'b0;
    end
  end

endmodule // timer8_waveform_modes

// >>> tb/timer8_pin_load.sv
// Load on one compare output pin: pull-down line and period meter.
// Assumes the pin changes only at hclk edges; period is in timer ticks.
`timescale 1ns/100ps
module timer8_pin_load
(
  input  wire         hclk,
  input  wire         timer_tick,
  input  wire         pin,
  input  wire         pin_en,
  output wire         level,
  output logic [15:0] period
);
  logic        prev = 1'b0;
  logic [15:0] cnt = 16'h0000;
  // A released pin is pulled low by the load
  assign level = pin_en ? pin : 1'b0;
  // Ticks between two rising edges of the line
  initial period = 16'h0000;
  always @(posedge hclk)
  begin
    prev <= level;
    cnt <= (level && !prev) ? 16'(timer_tick) : cnt + 16'(timer_tick);
    if (level && !prev)
      period <= cnt;
  end
endmodule // timer8_pin_load

// >>> tb/timer8_waveform_modes_asserts.sv
// Checker for the timer block: bus timing and pin update relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module timer8_waveform_modes_asserts
(
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        timer_tick,
  input wire        compare_output_a,
  input wire        compare_output_b,
  input wire        compare_output_a_en,
  input wire        compare_output_b_en
);
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire  rd_take;
  logic wr_dp;
  // Read address phase accepted in this cycle
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  // Write data phase in progress
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_dp <= 1'b0;
    else
      wr_dp <= hsel && hready && htrans[1] && hwrite;
  sequence s_take;
    hsel && hready && htrans[1];
  endsequence
  sequence s_read;
    s_take ##0 !hwrite;
  endsequence
  chk_ready_high: assert property (hreadyout)
    else $error("Slave inserted a wait state");
  chk_resp_okay: assert property (!hresp)
    else $error("Slave gave an error response");
  chk_a_on_tick: assert property
    ($changed(compare_output_a) |-> $past(timer_tick))
    else $error("Output A moved without a timer tick");
  chk_b_held: assert property
    (!timer_tick |=> $stable(compare_output_b))
    else $error("Output B moved without a timer tick");
  chk_ena_write: assert property
    ($changed(compare_output_a_en) |-> $past(wr_dp))
    else $error("Output A enable moved without a write");
  chk_enb_write: assert property
    ($changed(compare_output_b_en) |-> $past(wr_dp))
    else $error("Output B enable moved without a write");
  chk_rdata_stands: assert property ($changed(hrdata) |-> $past(rd_take))
    else $error("Read data moved without a read");
  chk_unmapped_zero: assert property
    (s_read ##0 (haddr[7:2] > 6'h04) |=> (hrdata == 32'h0))
    else $error("Unmapped read returned data");
endmodule // timer8_waveform_modes_asserts

bind timer8_waveform_modes timer8_waveform_modes_asserts chk_u
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .timer_tick(timer_tick),
  .compare_output_a(compare_output_a), .compare_output_b(compare_output_b),
  .compare_output_a_en(compare_output_a_en),
  .compare_output_b_en(compare_output_b_en)
);

// >>> tb/timer8_waveform_modes_tb_top.sv
// Bench for the timer block: bus tasks, tick pacing and a read monitor.
// Assumes hready is fed back from hreadyout and pins drive pull-down loads.
`timescale 1ns/100ps
`include "timer8_map.vh"
module timer8_waveform_modes_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        timer_tick = 1'b0;
  logic        rd_dp = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] v;
  logic [63:0] rq[$];
  wire  [31:0] hrdata;
  wire  [15:0] per_a;
  wire         hreadyout, hresp, oa, ob, oa_en, ob_en, la, lb;
  int          n_fail = 0;
  int          total_checks = 0;
  int          tcnt = 0;
  int          tmode = 0;
  logic [9:0]  en_tab [7] = '{{8'h53, 2'h0}, {8'h57, 2'h2}, {8'h51, 2'h0},
    {8'h55, 2'h2}, {8'h52, 2'h3}, {8'hA3, 2'h3}, {8'h83, 2'h2}};
  logic [31:0] per_tab [4] = '{{8'hB3, 8'h40, 16'h0100},
    {8'hB1, 8'h40, 16'h01FE}, {8'h47, 8'h10, 16'h0022},
    {8'h42, 8'h03, 16'h0008}};
  logic [25:0] lv_tab [3] = '{{8'hA3, 8'hFF, 8'hFF, 2'h3},
    {8'hA1, 8'h00, 8'hFF, 2'h1}, {8'hF1, 8'h00, 8'hFF, 2'h2}};
  timer8_waveform_modes dut_u
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_tick(timer_tick), .compare_output_a(oa), .compare_output_b(ob),
    .compare_output_a_en(oa_en), .compare_output_b_en(ob_en)
  );
  timer8_pin_load load_a
  (
    .hclk(hclk), .timer_tick(timer_tick), .pin(oa), .pin_en(oa_en),
    .level(la), .period(per_a)
  );
  timer8_pin_load load_b
  (
    .hclk(hclk), .timer_tick(timer_tick), .pin(ob), .pin_en(ob_en),
    .level(lb), .period()
  );
  // 40 MHz clock
  initial
    forever #12.5 hclk = ~hclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("Checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One single-word transfer; waits for hready in both phases
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask
  // Exactly n timer ticks, then one quiet edge
  task ticks(input int n);
    @(posedge hclk);
    tcnt <= n;
    @(posedge hclk);
    while (tcnt != 0) @(posedge hclk);
    @(posedge hclk);
  endtask
  task setup(input logic [7:0] ctl, a, b, c);
    bus(1'b1, `ADDR_CONTROL, 32'h0);
    bus(1'b1, `ADDR_CMP_A, {24'h0, a});
    bus(1'b1, `ADDR_CMP_B, {24'h0, b});
    bus(1'b1, `ADDR_COUNTER, {24'h0, c});
    bus(1'b1, `ADDR_FLAGS, 32'h7);
    bus(1'b1, `ADDR_CONTROL, {24'h0, ctl});
  endtask
  // Read monitor: compares each read data phase with the oldest note
  always @(posedge hclk)
  begin
    if (rd_dp && hreadyout)
    begin
      chk(hrdata & rq[0][63:32], rq[0][31:0]);
      void'(rq.pop_front());
    end
    rd_dp <= hsel && hreadyout && htrans[1] && !hwrite;
  end
  // Tick source: counted burst, else off, steady or random
  always @(posedge hclk)
    if (tcnt != 0)
    begin
      timer_tick <= 1'b1;
      tcnt <= tcnt - 1;
    end
    else
      timer_tick <= (tmode == 1) || (tmode == 2 && $urandom_range(1) == 1);
  initial
  begin
    void'($urandom(32'h66E2));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(8'(i * 4), 32'h0, 32'hFFFFFFFF);
    chk(32'({oa, ob, oa_en, ob_en}), 32'h0);
    setup(8'h00, 8'h05, 8'h00, 8'hFF);
    ticks(1);
    rd(`ADDR_COUNTER, 32'h0, 32'hFF);
    rd(`ADDR_FLAGS, 32'h1, 32'h1);
    repeat (4)
    begin
      v = $urandom_range(255);
      bus(1'b1, `ADDR_COUNTER, v);
      repeat (9) @(posedge hclk);
      rd(`ADDR_COUNTER, v, 32'hFF);
    end
    bus(1'b1, `ADDR_COUNTER, 32'h5);
    ticks(1);
    rd(`ADDR_COUNTER, 32'h6, 32'hFF);
    rd(`ADDR_FLAGS, 32'h0, 32'h2);
    bus(1'b1, `ADDR_COUNTER, 32'h4);
    ticks(2);
    rd(`ADDR_FLAGS, 32'h2, 32'h2);
    setup(8'hB3, 8'h40, 8'h40, 8'h01);
    ticks(64);
    chk(32'({la, lb}), 32'h1);
    rd(`ADDR_FLAGS, 32'h2, 32'h3);
    ticks(191);
    chk(32'({la, lb}), 32'h2);
    rd(`ADDR_FLAGS, 32'h1, 32'h1);
    setup(8'h07, 8'h10, 8'h00, 8'h0E);
    ticks(2);
    rd(`ADDR_COUNTER, 32'h10, 32'hFF);
    ticks(1);
    rd(`ADDR_COUNTER, 32'h0, 32'hFF);
    rd(`ADDR_FLAGS, 32'h1, 32'h1);
    chk(32'(oa), 32'h1);
    setup(8'h05, 8'h04, 8'h00, 8'h03);
    ticks(1);
    rd(`ADDR_COUNTER, 32'h4, 32'hFF);
    ticks(1);
    rd(`ADDR_COUNTER, 32'h3, 32'hFF);
    ticks(4);
    rd(`ADDR_COUNTER, 32'h1, 32'hFF);
    setup(8'hB1, 8'h40, 8'h40, 8'h01);
    ticks(64);
    chk(32'({la, lb}), 32'h1);
    ticks(382);
    chk(32'({la, lb}), 32'h2);
    rd(`ADDR_FLAGS, 32'h0, 32'h1);
    ticks(63);
    rd(`ADDR_FLAGS, 32'h1, 32'h1);
    setup(8'h42, 8'h03, 8'h00, 8'h00);
    ticks(4);
    rd(`ADDR_COUNTER, 32'h0, 32'hFF);
    rd(`ADDR_FLAGS, 32'h2, 32'h2);
    bus(1'b1, `ADDR_COUNTER, 32'hFE);
    ticks(2);
    rd(`ADDR_COUNTER, 32'h0, 32'hFF);
    rd(`ADDR_FLAGS, 32'h1, 32'h1);
    setup(8'h02, 8'hFF, 8'h00, 8'hFE);
    ticks(2);
    rd(`ADDR_COUNTER, 32'h0, 32'hFF);
    rd(`ADDR_FLAGS, 32'h3, 32'h3);
    setup(8'h06, 8'h05, 8'h00, 8'hFE);
    ticks(2);
    rd(`ADDR_COUNTER, 32'h0, 32'hFF);
    rd(`ADDR_FLAGS, 32'h1, 32'h1);
    foreach (en_tab[i])
    begin
      bus(1'b1, `ADDR_CONTROL, 32'(en_tab[i][9:2]));
      #1;
      chk(32'({oa_en, ob_en}), 32'(en_tab[i][1:0]));
    end
    foreach (per_tab[i])
    begin
      setup(per_tab[i][31:24], per_tab[i][23:16], per_tab[i][23:16], 8'h00);
      tmode <= 2;
      repeat (3200) @(posedge hclk);
      tmode <= 0;
      chk(32'(per_a), 32'(per_tab[i][15:0]));
    end
    foreach (lv_tab[i])
    begin
      setup(lv_tab[i][25:18], lv_tab[i][17:10], lv_tab[i][9:2], 8'h00);
      tmode <= 1;
      repeat (600) @(posedge hclk);
      repeat (8)
      begin
        repeat (37) @(posedge hclk);
        chk(32'({la, lb}), 32'(lv_tab[i][1:0]));
      end
      tmode <= 0;
    end
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #1000000;
    n_fail++;
    give_verdict();
  end
endmodule // timer8_waveform_modes_tb_top
